// File: event_edge_detect.sv
// Synchroniser and edge detector for the external event input.
// Assumes the pin is asynchronous to the core clock.
`timescale 1ns/1ps

module event_edge_detect (
	// Clock and reset.
	input  wire logic I_CORE_CLK,
	input  wire logic I_RST,
	// Pin and edge choice.
	input  wire logic i_pin,
	input  wire logic i_rising,
	// One-cycle tick per chosen edge.
	output logic      o_tick
);
	logic sync_a;
	logic sync_b;
	logic last;

	// The first stage feeds only the second, so metastability cannot spread.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			last   <= 1'b0;
		end else begin
			sync_a <= i_pin;
			sync_b <= sync_a;
			last   <= sync_b;
		end
	end

	assign o_tick = i_rising ? (sync_b & ~last) : (~sync_b & last);

endmodule : event_edge_detect

// File: reload_interval_event_timer.sv
// Top level of the reload interval event timer with its register port.
// Assumes a single-cycle strobe master and a power mode supplied by the system.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps

module reload_interval_event_timer
	import reload_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic                          I_CORE_CLK,
	input  wire logic                          I_RST,
	// Register port.
	input  wire logic [15:0]                   I_ADDR,
	input  wire logic [7:0]                    I_WDATA,
	input  wire logic                          I_WR,
	input  wire logic                          I_RD,
	output logic      [7:0]                    O_RDATA,
	// System.
	input  wire reload_timer_pkg::power_mode_t I_POWER_MODE,
	input  wire logic                          I_EVENT_PIN,
	// Status outputs.
	output logic                               O_IRQ,
	output logic                               O_OVERFLOW,
	output logic                               O_PIN_FUNCTION,
	output logic                               O_EXT_IRQ_ENABLE
);
	import reload_timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// State.
	reg_req_t          req;
	logic              reload_select;
	logic [2:0]        clock_select;
	logic [7:0]        count_value;
	logic [7:0]        reload_value;
	logic [7:0]        irq_status;
	logic [7:0]        irq_mask;
	logic [7:0]        ctrl;
	logic [PRESCALE_BITS-1:0] prescale;
	logic              tap_last;
	logic              tap_now;
	logic              event_tick;
	logic              tick;
	logic              running;
	logic              overflow;
	logic              reload_wr;
	logic [7:0]        next_status;
	logic [7:0]        next_mask;
	logic [7:0]        next_ctrl;

	assign req.addr  = I_ADDR;
	assign req.wdata = I_WDATA;
	assign req.wr    = I_WR;
	assign req.rd    = I_RD;

	// Halting in low-power modes also freezes the prescaler, so no stale tick fires on wake.
	assign running   = (I_POWER_MODE == PM_ACTIVE) || (I_POWER_MODE == PM_SLEEP);
	assign reload_wr = req.wr && (req.addr == ADDR_COUNT);

	////////////////////////////////////////////////////////////////////////////
	// Tick sources.
	event_edge_detect u_edge (
		.I_CORE_CLK (I_CORE_CLK),
		.I_RST      (I_RST),
		.i_pin      (I_EVENT_PIN),
		.i_rising   (ctrl[CTRL_EDGE_BIT]),
		.o_tick     (event_tick)
	);

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			prescale <= '0;
			tap_last <= 1'b0;
		end else if (running) begin
			prescale <= prescale + 1'b1;
			tap_last <= tap_now;
		end
	end

	// A tap's falling edge is one tick per full divide period.
	assign tap_now = prescale[tap_index(clock_select)];
	assign tick    = running && ((clock_select == SEL_EXTERNAL) ? event_tick
	                                                           : (tap_last & ~tap_now));
	assign overflow = tick && (count_value == COUNT_TOP);

	////////////////////////////////////////////////////////////////////////////
	// Mode register.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			reload_select <= MODE_RESET[MODE_RELOAD_BIT];
			clock_select  <= MODE_RESET[2:0];
		end else if (req.wr && req.addr == ADDR_MODE && I_POWER_MODE == PM_ACTIVE) begin
			reload_select <= req.wdata[MODE_RELOAD_BIT];
			clock_select  <= req.wdata[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reload and counter.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			reload_value <= RELOAD_RESET;
		end else if (reload_wr) begin
			reload_value <= req.wdata;
		end
	end

	// A reload write wins over a tick in the same cycle: software's value is the start point.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			count_value <= COUNT_RESET;
		end else if (reload_wr) begin
			count_value <= req.wdata;
		end else if (overflow) begin
			count_value <= reload_select ? reload_value : 8'h00;
		end else if (tick) begin
			count_value <= count_value + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and pin control.
	always_comb begin
		next_status = irq_status;
		if (req.wr && req.addr == ADDR_IRQ_ST) begin
			next_status = irq_status & ~req.wdata;
		end
		if (overflow) begin
			next_status[IRQ_OVF_BIT] = 1'b1;
		end
		next_status[7:1] = 7'h00;
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			irq_status <= 8'h00;
		end else begin
			irq_status <= next_status;
		end
	end

	// Outputs follow the value being written, so a mask or control write shows at once.
	always_comb begin
		next_mask = irq_mask;
		next_ctrl = ctrl;
		if (req.wr && req.addr == ADDR_IRQ_EN) begin
			next_mask = {7'h00, req.wdata[IRQ_OVF_BIT]};
		end
		if (req.wr && req.addr == ADDR_CTRL) begin
			next_ctrl = {5'h00, req.wdata[2:0]};
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			irq_mask <= 8'h00;
			ctrl     <= 8'h00;
		end else begin
			irq_mask <= next_mask;
			ctrl     <= next_ctrl;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_IRQ            <= 1'b0;
			O_OVERFLOW       <= 1'b0;
			O_PIN_FUNCTION   <= 1'b0;
			O_EXT_IRQ_ENABLE <= 1'b0;
		end else begin
			O_IRQ            <= |(next_status & next_mask);
			O_OVERFLOW       <= next_status[IRQ_OVF_BIT];
			O_PIN_FUNCTION   <= next_ctrl[CTRL_PINFN_BIT];
			O_EXT_IRQ_ENABLE <= next_ctrl[CTRL_EXTIE_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port.
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				ADDR_MODE:   O_RDATA <= {reload_select, 4'hf, clock_select};
				ADDR_COUNT:  O_RDATA <= count_value;
				ADDR_IRQ_ST: O_RDATA <= irq_status;
				ADDR_IRQ_EN: O_RDATA <= irq_mask;
				ADDR_CTRL:   O_RDATA <= ctrl;
				default:     O_RDATA <= 8'h00;
			endcase
		end else begin
			O_RDATA <= 8'h00;
		end
	end

endmodule : reload_interval_event_timer

// File: reload_interval_event_timer_tb_top.sv
// Self-checking bench for the reload interval event timer.
// Assumes the package, the design and the monitor are compiled first.
`timescale 1ns/1ps
module reload_interval_event_timer_tb_top;
	import reload_timer_pkg::*;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, pin = 0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  rdata, d, s, v;
	logic        irq, ovf, pfn, eie;
	power_mode_t pmode = PM_ACTIVE;
	logic [31:0] seed = 32'h7d52b4cd;
	int          fail_count = 0, checked = 0, n;
	int          dv[7] = '{8192, 2048, 512, 256, 64, 16, 4};
	reload_interval_event_timer reload_interval_event_timer_inst (.I_CORE_CLK(clk),
		.I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_POWER_MODE(pmode), .I_EVENT_PIN(pin), .O_IRQ(irq),
		.O_OVERFLOW(ovf), .O_PIN_FUNCTION(pfn), .O_EXT_IRQ_ENABLE(eie));
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] mode_exp(input logic [7:0] m);
		return {m[7], 4'hf, m[2:0]};
	endfunction : mode_exp
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] x);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= x;
		@(posedge clk);
		wr <= 0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [15:0] a);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 d = rdata;
	endtask : rd_reg
	// Auto-reload values stay below 0xf8 so a fresh overflow cannot race the clear.
	task automatic ovf_run(input logic [7:0] m, input logic [7:0] r, input logic en);
		wr_reg(ADDR_MODE, m);
		wr_reg(ADDR_IRQ_EN, {7'h00, en});
		wr_reg(ADDR_COUNT, r);
		rd_reg(ADDR_COUNT);
		n = 0;
		while (ovf !== 1'b1 && n < 2000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({6'h00, irq, ovf}, {6'h00, en, 1'b1});
		rd_reg(ADDR_COUNT);
		chk(8'(d - (m[7] ? r : 8'h00) < 8'h03), 8'h01);
		rd_reg(ADDR_IRQ_ST);
		chk(d, 8'h01);
		wr_reg(ADDR_IRQ_EN, 8'h00);
		wr_reg(ADDR_IRQ_ST, 8'h01);
		rd_reg(ADDR_IRQ_ST);
		chk(d, 8'h00);
	endtask : ovf_run
	task automatic finish_test();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////
	initial forever #2.5 clk = ~clk;
	initial begin
		#600000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_reg(ADDR_MODE);
		chk(d, 8'h78);
		rd_reg(ADDR_COUNT);
		chk(d, 8'h00);
		rd_reg(16'hffb0);
		chk(d, 8'h00);
		for (int c = 0; c < 7; c++) begin
			v = rnd();
			v[2:0] = 3'(c);
			wr_reg(ADDR_MODE, v);
			rd_reg(ADDR_MODE);
			chk(d, mode_exp(v));
			wr_reg(ADDR_COUNT, 8'h00);
			repeat (4 * dv[c]) @(posedge clk);
			rd_reg(ADDR_COUNT);
			chk(8'(d inside {[8'h03:8'h05]}), 8'h01);
		end
		ovf_run(8'h06, 8'hfd, 1'b0);
		v = rnd();
		ovf_run(8'h86, {5'h1e, v[2:0]}, 1'b1);
		for (int e = 0; e < 2; e++) begin
			wr_reg(ADDR_CTRL, 8'h02 | 8'(e));
			chk({6'h00, eie, pfn}, 8'h01);
			wr_reg(ADDR_MODE, 8'h07);
			wr_reg(ADDR_COUNT, 8'h00);
			v = (rnd() & 8'h0f) + 8'h01;
			repeat (2 * v) begin
				repeat (4) @(posedge clk);
				pin <= ~pin;
			end
			repeat (8) @(posedge clk);
			rd_reg(ADDR_COUNT);
			chk(d, v);
		end
		wr_reg(ADDR_MODE, 8'h06);
		pmode <= PM_WATCH;
		wr_reg(ADDR_MODE, 8'h81);
		rd_reg(ADDR_MODE);
		chk(d, 8'h7e);
		rd_reg(ADDR_COUNT);
		s = d;
		rd_reg(ADDR_COUNT);
		repeat (20) @(posedge clk);
		rd_reg(ADDR_COUNT);
		chk(d, s);
		pmode <= PM_SLEEP;
		repeat (20) @(posedge clk);
		rd_reg(ADDR_COUNT);
		chk(8'(d != s), 8'h01);
		finish_test();
	end
endmodule : reload_interval_event_timer_tb_top
bind reload_interval_event_timer reload_timer_monitor reload_timer_monitor_inst (.I_CORE_CLK,
	.I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA, .I_POWER_MODE, .O_IRQ, .O_OVERFLOW,
	.O_PIN_FUNCTION, .O_EXT_IRQ_ENABLE);

// File: reload_timer_monitor.sv
// Port checks for the reload interval event timer.
// Assumes a bind to the top module, all in one clock domain.
`timescale 1ns/1ps
module reload_timer_monitor (
	input wire logic                          I_CORE_CLK,
	input wire logic                          I_RST,
	input wire logic [15:0]                   I_ADDR,
	input wire logic [7:0]                    I_WDATA,
	input wire logic                          I_WR,
	input wire logic                          I_RD,
	input wire logic [7:0]                    O_RDATA,
	input wire reload_timer_pkg::power_mode_t I_POWER_MODE,
	input wire logic                          O_IRQ,
	input wire logic                          O_OVERFLOW,
	input wire logic                          O_PIN_FUNCTION,
	input wire logic                          O_EXT_IRQ_ENABLE
);
	import reload_timer_pkg::*;
	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (I_RST);
	sequence s_load;
		I_WR && I_ADDR == ADDR_COUNT;
	endsequence
	sequence s_read;
		I_RD && I_ADDR == ADDR_COUNT;
	endsequence
	sequence s_halt_read;
		s_read ##0 I_POWER_MODE > PM_SLEEP;
	endsequence
	////////////////////////////////////////////////////////////////////////////
	// A tick may land between load and read, so one step of slack is allowed.
	a_load_count: assert property (s_load ##2 s_read |=>
		8'(O_RDATA - $past(I_WDATA, 3)) <= 8'h01) else $error("count load lost");
	a_halt_frozen: assert property (s_halt_read ##2 s_halt_read |=>
		O_RDATA == $past(O_RDATA, 2)) else $error("count moved while halted");
	a_reserved_ones: assert property (I_RD && I_ADDR == ADDR_MODE |=>
		O_RDATA[6:3] == 4'hf) else $error("reserved mode bits not one");
	a_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
		else $error("read data outside read slot");
	a_irq_gated: assert property (O_IRQ |-> O_OVERFLOW)
		else $error("irq without flag");
	a_mask_off: assert property (I_WR && I_ADDR == ADDR_IRQ_EN && !I_WDATA[0] |=>
		!O_IRQ) else $error("irq while masked");
	a_flag_sticky: assert property (O_OVERFLOW &&
		!(I_WR && I_ADDR == ADDR_IRQ_ST && I_WDATA[0]) |=> O_OVERFLOW)
		else $error("flag dropped without clear");
	a_reset_quiet: assert property ($past(I_RST) |-> !O_IRQ && !O_OVERFLOW &&
		!O_PIN_FUNCTION && !O_EXT_IRQ_ENABLE) else $error("outputs set after reset");
	a_ctrl_export: assert property (I_WR && I_ADDR == ADDR_CTRL |=>
		{O_EXT_IRQ_ENABLE, O_PIN_FUNCTION} == $past(I_WDATA[2:1]))
		else $error("control bits not exported");
endmodule : reload_timer_monitor

// File: reload_timer_pkg.sv
// Constants and types for the reload interval event timer.
// Assumes one 200 MHz core clock and a plain strobe register port.
//
// How it works
// - Mode register resets to 0x78: interval mode, clock select 000.
// - Mode bit 7 picks interval (0) or auto-reload (1) operation.
// - Mode bits 6 to 3 always read 1 and ignore writes.
// - Clock select 000..110 picks prescaler taps 8192..4; 111 picks external events.
// - Count register is an up-counter, readable at any time; a write loads it and the reload value.
// - A tick while count is 0xFF overflows and sets the overflow flag.
// - Overflow requests an interrupt only while its enable bit is 1.
// - In interval mode the counter wraps to 0x00 and keeps counting.
// - In interval mode a reload write also loads the counter.
// - In auto-reload mode overflow loads the reload value into the counter.
// - In auto-reload mode a reload write also loads the counter at once.
// - Reset clears counter and reload value to 0x00; counting starts at once.
// - Clock select 111 counts rising or falling event pin edges, per edge select.
// - Counter runs in active and sleep, halts otherwise; mode writable only when active.

package reload_timer_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses.
	localparam logic [15:0] ADDR_MODE   = 16'hffb2;
	localparam logic [15:0] ADDR_COUNT  = 16'hffb3;
	localparam logic [15:0] ADDR_IRQ_ST = 16'hffb4;
	localparam logic [15:0] ADDR_IRQ_EN = 16'hffb5;
	localparam logic [15:0] ADDR_CTRL   = 16'hffb6;

	////////////////////////////////////////////////////////////////////////////
	// Field positions and reset values.
	localparam int          MODE_RELOAD_BIT = 7;
	localparam logic [7:0]  MODE_RESERVED   = 8'h78;
	localparam logic [7:0]  MODE_RESET      = 8'h78;
	localparam logic [7:0]  COUNT_RESET     = 8'h00;
	localparam logic [7:0]  RELOAD_RESET    = 8'h00;
	localparam logic [7:0]  COUNT_TOP       = 8'hff;
	localparam logic [2:0]  SEL_EXTERNAL    = 3'h7;
	localparam int          IRQ_OVF_BIT     = 0;
	localparam int          CTRL_EDGE_BIT   = 0;
	localparam int          CTRL_PINFN_BIT  = 1;
	localparam int          CTRL_EXTIE_BIT  = 2;

	////////////////////////////////////////////////////////////////////////////
	// Prescaler.
	localparam int PRESCALE_BITS = 13;

	typedef enum logic [2:0] {
		PM_ACTIVE,
		PM_SLEEP,
		PM_WATCH,
		PM_SUBACTIVE,
		PM_SUBSLEEP,
		PM_STANDBY
	} power_mode_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	// Tap index into the free-running prescaler for one clock select code.
	function automatic logic [3:0] tap_index(input logic [2:0] sel);
		case (sel)
			3'h0:    tap_index = 4'hc;
			3'h1:    tap_index = 4'ha;
			3'h2:    tap_index = 4'h8;
			3'h3:    tap_index = 4'h7;
			3'h4:    tap_index = 4'h5;
			3'h5:    tap_index = 4'h3;
			default: tap_index = 4'h1;
		endcase
	endfunction : tap_index

endpackage : reload_timer_pkg
